// ### logic/isc_pkg.sv
// constants, types and behaviour notes for the interrupt and standby block
// Notes on behaviour
// - watchdog non-maskable line, taken before maskable ones
// - watchdog enable input can suppress the line
// - line blocked until writes to 00FF00H and 00FF01H
// - ten systems, 22 types, flag and enable each
// - fixed grouping of types into systems
// - each system has a three-level priority
// - event sets its pending flag, readable
// - enable bit one allows, zero blocks request
// - accept: flag, enable, priority above cpu mask
// - requests sampled at first opcode fetch
// - halt stops cpu, peripherals keep running
// - halt ends on reset or any request
// - sleep stops cpu and both oscillators
// - sleep ends on reset, nmi, port interrupt
// - writing one clears flag, zero after reset
package isc_pkg;
  localparam int NUM_TYPES   = 22;
  localparam int NUM_SYS     = 10;
  localparam int LVL_W       = 2;
  localparam int SYS_W       = 4;
  // io addresses whose writes release the nmi block
  localparam logic [23:0] NMI_REL_ADDR0 = 24'h00_FF00;
  localparam logic [23:0] NMI_REL_ADDR1 = 24'h00_FF01;
  // system numbers
  localparam logic [3:0] SYS_K0   = 4'h0;
  localparam logic [3:0] SYS_K1   = 4'h1;
  localparam logic [3:0] SYS_T16A = 4'h2;
  localparam logic [3:0] SYS_T16B = 4'h3;
  localparam logic [3:0] SYS_T8   = 4'h4;
  localparam logic [3:0] SYS_SER  = 4'h5;
  localparam logic [3:0] SYS_TP   = 4'h6;
  localparam logic [3:0] SYS_LCD  = 4'h7;
  localparam logic [3:0] SYS_AD   = 4'h8;
  localparam logic [3:0] SYS_CTM  = 4'h9;
  // reset values
  localparam logic [21:0] FLAGS_RST = 22'h00_0000;
  localparam logic [21:0] EN_RST    = 22'h00_0000;
  localparam logic [19:0] PRIO_RST  = 20'h0_0000;

  typedef enum logic [1:0] {
    ISC_RUN,
    ISC_HALT,
    ISC_SLEEP
  } isc_mode_t;

  // map type index to system: k0 0, k1 1-4, t16a 5-6, t16b 7-8, t8 9,
  // serial 10-12, touch 13-14, lcd 15, adc 16, clock timer 17-21
  function automatic logic [3:0] isc_sys_of(input int t);
    logic [3:0] s;
    s = SYS_CTM;
    if (t == 0) s = SYS_K0;
    else if (t <= 4) s = SYS_K1;
    else if (t <= 6) s = SYS_T16A;
    else if (t <= 8) s = SYS_T16B;
    else if (t == 9) s = SYS_T8;
    else if (t <= 12) s = SYS_SER;
    else if (t <= 14) s = SYS_TP;
    else if (t == 15) s = SYS_LCD;
    else if (t == 16) s = SYS_AD;
    return s;
  endfunction : isc_sys_of
endpackage : isc_pkg

// ### logic/isc_req_if.sv
// carrier between the controller and its priority resolver
`timescale 1ns/1ps
interface isc_req_if #(
  parameter int NSYS = 10
);
  logic [NSYS-1:0]   sys_req;
  logic [2*NSYS-1:0] sys_lvl;
  logic [1:0]        mask;
  logic              win_valid;
  logic [3:0]        win_sys;
  logic [1:0]        win_lvl;

  modport ctl (
    output sys_req, sys_lvl, mask,
    input  win_valid, win_sys, win_lvl
  );
  modport res (
    input  sys_req, sys_lvl, mask,
    output win_valid, win_sys, win_lvl
  );
endinterface : isc_req_if

// ### logic/isc_prio.sv
// priority resolver: highest level above the cpu mask, lowest system on tie
`timescale 1ns/1ps
module isc_prio #(
  parameter int NSYS = 10
) (
  isc_req_if.res req
);
  if (NSYS < 1 || NSYS > 16) begin : g_chk
    $error("isc_prio: NSYS must be 1..16");
  end

  always_comb begin
    logic [1:0] best;
    logic [1:0] lv;
    best = 2'h0;
    lv = 2'h0;
    req.win_valid = 1'b0;
    req.win_sys = 4'h0;
    req.win_lvl = 2'h0;
    for (int s = NSYS - 1; s >= 0; s--) begin
      lv = req.sys_lvl[2*s +: 2];
      if (req.sys_req[s] && lv > req.mask && lv >= best) begin
        best = lv;
        req.win_valid = 1'b1;
        req.win_sys = s[3:0];
        req.win_lvl = lv;
      end
    end
  end
endmodule : isc_prio

// ### logic/isc_top.sv
// interrupt collection, nmi gating and standby control
`timescale 1ns/1ps
module isc_top #(
  parameter int NTYPES = 22,
  parameter int NSYS   = 10
) (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // peripheral events, one-cycle pulses, and the watchdog nmi enable level
  input  wire logic [NTYPES-1:0] evt_in,
  input  wire logic              wdt_nmi_evt_in,
  input  wire logic              wdt_nmi_en_in,
  // software access strobes
  input  wire logic              io_wr_in,
  input  wire logic [23:0]       io_addr_in,
  input  wire logic [NTYPES-1:0] flag_clr_in,
  input  wire logic              en_wr_in,
  input  wire logic [NTYPES-1:0] en_data_in,
  input  wire logic              prio_wr_in,
  input  wire logic [2*NSYS-1:0] prio_data_in,
  // cpu side
  input  wire logic              cpu_level_mask_bit0_in,
  input  wire logic              cpu_level_mask_bit1_in,
  input  wire logic              fetch_first_in,
  input  wire logic              halt_instruction_in,
  input  wire logic              sleep_instruction_in,
  // status
  output logic [NTYPES-1:0]      flags_out,
  output logic [NTYPES-1:0]      enable_out,
  output logic [2*NSYS-1:0]      prio_out,
  output logic [NSYS-1:0]        sys_req_out,
  output logic                   nmi_unblocked_out,
  // cpu requests
  output logic                   nmi_take_out,
  output logic                   irq_take_out,
  output logic [3:0]             irq_sys_out,
  output logic [1:0]             irq_lvl_out,
  // standby
  output logic                   cpu_stop_out,
  output logic                   low_speed_oscillator_stop_out,
  output logic                   high_speed_oscillator_stop_out,
  output logic                   wake_out
);
  if (NTYPES != isc_pkg::NUM_TYPES || NSYS != isc_pkg::NUM_SYS) begin : g_chk
    $error("isc_top: type and system counts are fixed by the grouping");
  end

  // whole block state, registered once per clock
  typedef struct packed {
    logic [NTYPES-1:0]  flags;
    logic [NTYPES-1:0]  en;
    logic [2*NSYS-1:0]  prio;
    // sticky release writes, cleared only by reset
    logic               rel0;
    logic               rel1;
    logic               nmi_pend;
    isc_pkg::isc_mode_t mode;
    logic               nmi_take;
    logic               irq_take;
    // last accepted system and level, held until the next take
    logic [3:0]         sys;
    logic [1:0]         lvl;
    logic               wake;
  } isc_state_t;

  isc_state_t st;
  isc_state_t next_st;

  isc_req_if #(.NSYS(NSYS)) req ();

  // resolver sees requests, levels and the live cpu mask
  isc_prio #(.NSYS(NSYS)) u_prio (
    .req (req.res)
  );

  logic [NSYS-1:0] sys_req;
  logic            nmi_ok;
  logic            wdt_nmi;

  // per-system request from enabled pending types
  always_comb begin
    sys_req = '0;
    for (int t = 0; t < NTYPES; t++) begin
      if (st.flags[t] && st.en[t]) begin
        sys_req[isc_pkg::isc_sys_of(t)] = 1'b1;
      end
    end
  end

  assign req.sys_req = sys_req;
  assign req.sys_lvl = st.prio;
  assign req.mask    = {cpu_level_mask_bit1_in, cpu_level_mask_bit0_in};
  assign nmi_ok      = st.rel0 && st.rel1;
  // watchdog raises nothing unless configured to
  assign wdt_nmi     = wdt_nmi_evt_in && wdt_nmi_en_in;

  always_comb begin
    logic port_req;
    logic any_req;
    // only the port systems may end sleep among the maskable ones
    port_req = sys_req[isc_pkg::SYS_K0] || sys_req[isc_pkg::SYS_K1];
    any_req = |sys_req;
    next_st = st;
    next_st.nmi_take = 1'b0;
    next_st.irq_take = 1'b0;
    next_st.wake = 1'b0;
    next_st.flags = st.flags & ~flag_clr_in;
    // event sets flag, set wins over clear
    // a clear never swallows an event of the same cycle
    // one flag per type
    next_st.flags = next_st.flags | evt_in;
    if (en_wr_in) begin
      next_st.en = en_data_in;
    end
    if (prio_wr_in) begin
      next_st.prio = prio_data_in;
    end
    // release after writes to both addresses
    // either order; each address write is remembered
    if (io_wr_in && io_addr_in == isc_pkg::NMI_REL_ADDR0) begin
      next_st.rel0 = 1'b1;
    end
    if (io_wr_in && io_addr_in == isc_pkg::NMI_REL_ADDR1) begin
      next_st.rel1 = 1'b1;
    end
    // watchdog may be set to raise no nmi
    // nmi cannot be masked by the level mask
    if (wdt_nmi && nmi_ok) begin
      next_st.nmi_pend = 1'b1;
    end
    case (st.mode)
      isc_pkg::ISC_RUN: begin
        if (fetch_first_in) begin
          if (st.nmi_pend) begin
            next_st.nmi_take = 1'b1;
            // an event landing on the take cycle stays pending
            next_st.nmi_pend = wdt_nmi && nmi_ok;
          end else if (req.win_valid) begin
            // accepted request
            // the flag stays set; the handler has to clear it
            next_st.irq_take = 1'b1;
            next_st.sys = req.win_sys;
            next_st.lvl = req.win_lvl;
          end
        end
        if (halt_instruction_in) begin
          next_st.mode = isc_pkg::ISC_HALT;
        end else if (sleep_instruction_in) begin
          next_st.mode = isc_pkg::ISC_SLEEP;
        end
      end
      isc_pkg::ISC_HALT: begin
        // any request ends halt
        // the cpu mask does not hold off this wake
        if (any_req || st.nmi_pend) begin
          next_st.mode = isc_pkg::ISC_RUN;
          next_st.wake = 1'b1;
        end
      end
      isc_pkg::ISC_SLEEP: begin
        // only nmi or port interrupt ends sleep
        if (port_req || st.nmi_pend) begin
          next_st.mode = isc_pkg::ISC_RUN;
          next_st.wake = 1'b1;
        end
      end
      default: begin
        // unused encoding falls back to run
        next_st.mode = isc_pkg::ISC_RUN;
      end
    endcase
  end

  // every field reset from a constant, one register for the whole state
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st.flags    <= isc_pkg::FLAGS_RST;
      st.en       <= isc_pkg::EN_RST;
      st.prio     <= isc_pkg::PRIO_RST;
      st.rel0     <= 1'b0;
      st.rel1     <= 1'b0;
      st.nmi_pend <= 1'b0;
      st.mode     <= isc_pkg::ISC_RUN;
      st.nmi_take <= 1'b0;
      st.irq_take <= 1'b0;
      st.sys      <= 4'h0;
      st.lvl      <= 2'h0;
      st.wake     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // status and requests read straight from the state
  assign flags_out         = st.flags;
  assign enable_out        = st.en;
  assign prio_out          = st.prio;
  assign sys_req_out       = sys_req;
  assign nmi_unblocked_out = nmi_ok;
  assign nmi_take_out      = st.nmi_take;
  assign irq_take_out      = st.irq_take;
  assign irq_sys_out       = st.sys;
  assign irq_lvl_out       = st.lvl;
  assign cpu_stop_out      = st.mode != isc_pkg::ISC_RUN;
  // the block stays clocked; the stop lines gate the oscillators
  assign low_speed_oscillator_stop_out  = st.mode == isc_pkg::ISC_SLEEP;
  assign high_speed_oscillator_stop_out = st.mode == isc_pkg::ISC_SLEEP;
  assign wake_out          = st.wake;
endmodule : isc_top

// ### tb/isc_sva.sv
// port checker for the interrupt and standby block
`timescale 1ns/1ps
module isc_sva #(parameter int NTYPES = 22, parameter int NSYS = 10) (
  // clock, reset and cpu side
  input wire logic mclk_in, rst_b_in, fetch_first_in, halt_instruction_in,
  input wire logic cpu_level_mask_bit0_in, cpu_level_mask_bit1_in,
  // flags and requests
  input wire logic [NTYPES-1:0] evt_in, flag_clr_in, flags_out,
  input wire logic [NSYS-1:0] sys_req_out,
  input wire logic [1:0] irq_lvl_out,
  input wire logic nmi_unblocked_out, nmi_take_out, irq_take_out, wake_out,
  // standby
  input wire logic cpu_stop_out, low_speed_oscillator_stop_out
);
  logic [NTYPES-1:0] evt_q, clr_q;
  wire sleep_instruction = low_speed_oscillator_stop_out;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // set wins over a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    evt_q <= evt_in;
    clr_q <= flag_clr_in & ~evt_in;
  end
  flag_set_a: assert property (
    |evt_q |-> (flags_out & evt_q) == evt_q) else $error("flag not set");
  flag_clr_a: assert property (
    |clr_q |-> (flags_out & clr_q) == 0) else $error("flag not cleared");
  nmi_block_a: assert property (
    !nmi_unblocked_out |-> !nmi_take_out) else $error("nmi while blocked");
  nmi_first_a: assert property (
    nmi_take_out |-> !irq_take_out) else $error("irq beside nmi");
  irq_level_a: assert property (
    irq_take_out |-> irq_lvl_out >
      {$past(cpu_level_mask_bit1_in), $past(cpu_level_mask_bit0_in)})
    else $error("level not above mask");
  irq_fetch_a: assert property (
    irq_take_out |-> $past(fetch_first_in) && !$past(cpu_stop_out))
    else $error("take without fetch");
  halt_in_a: assert property (
    halt_instruction_in && !cpu_stop_out |=> cpu_stop_out && !sleep_instruction)
    else $error("halt not entered");
  halt_wake_a: assert property (
    cpu_stop_out && !sleep_instruction && |sys_req_out |=> !cpu_stop_out && wake_out)
    else $error("halt not left");
  sleep_wake_a: assert property (
    sleep_instruction && |sys_req_out[1:0] |=> !cpu_stop_out && wake_out)
    else $error("sleep not left");
  irq_c: cover property (irq_take_out);
  nmi_c: cover property (nmi_take_out);
  wake_c: cover property (wake_out && $past(sleep_instruction));
endmodule : isc_sva

// ### tb/isc_cpu_model.sv
// cpu core stand-in: first opcode fetch strobes while running
`timescale 1ns/1ps
module isc_cpu_model #(parameter int GAP = 2) (
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  input  wire logic cpu_stop_in,
  output logic      fetch_first_out
);
  int cnt = 0;
  always @(posedge mclk_in) begin
    cnt <= (!rst_b_in || cpu_stop_in || cnt == GAP) ? 0 : cnt + 1;
    fetch_first_out <= rst_b_in && !cpu_stop_in && cnt == GAP;
  end
endmodule : isc_cpu_model

// ### tb/testbench.sv
// self-checking bench for the interrupt and standby block
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 0, rst_b_in = 0, wdt_nmi_evt_in = 0, wdt_nmi_en_in = 0;
  logic io_wr_in = 0, en_wr_in = 0, prio_wr_in = 0, fetch_first_in;
  logic cpu_level_mask_bit0_in = 0, cpu_level_mask_bit1_in = 0;
  logic halt_instruction_in = 0, sleep_instruction_in = 0, wake_out;
  logic [21:0] evt_in = 0, flag_clr_in = 0, en_data_in = 0, flags_out;
  logic [21:0] enable_out, mf = 0, me = 0;
  logic [19:0] prio_data_in = 0, prio_out, mp = 0;
  logic [23:0] io_addr_in = 0;
  logic [9:0] sys_req_out;
  logic [3:0] irq_sys_out;
  logic [1:0] irq_lvl_out;
  logic nmi_unblocked_out, nmi_take_out, irq_take_out, cpu_stop_out;
  logic low_speed_oscillator_stop_out, high_speed_oscillator_stop_out;
  int mode = 0, seed = 32'h2a6d_aaec, num_errors = 0, check_count = 0;
  int cyc = 0, nmi_cnt = 0;
  int sys_of[22] = '{0,1,1,1,1,2,2,3,3,4,5,5,5,6,6,7,8,9,9,9,9,9};

  isc_top uut (.*);
  isc_cpu_model cpu (.mclk_in, .rst_b_in, .cpu_stop_in(cpu_stop_out),
    .fetch_first_out(fetch_first_in));

  initial forever #2 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    nmi_cnt += nmi_take_out;
    if (cyc == 9000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  function automatic logic [9:0] reqs(input logic [21:0] f);
    reqs = '0;
    for (int t = 0; t < 22; t++) reqs[sys_of[t]] |= f[t];
  endfunction : reqs

  // one clock: model takes what the design sampled, new stimulus, compare
  task automatic step;
    logic [9:0] r;
    int w, wl, lv;
    logic et, ew;
    @(posedge mclk_in);
    r = reqs(mf & me);
    wl = 0;
    w = 0;
    for (int s = 9; s >= 0; s--) begin
      lv = mp[2*s+:2];
      if (r[s] && lv >= wl &&
          lv > {cpu_level_mask_bit1_in, cpu_level_mask_bit0_in}) begin
        w = s;
        wl = lv;
      end
    end
    et = fetch_first_in && mode == 0 && wl > 0;
    ew = (mode == 1 && r != 0) || (mode == 2 && r[1:0] != 0);
    if (ew) mode = 0;
    else if (mode == 0 && halt_instruction_in) mode = 1;
    else if (mode == 0 && sleep_instruction_in) mode = 2;
    mf = (mf & ~flag_clr_in) | evt_in;
    if (en_wr_in) me = en_data_in;
    if (prio_wr_in) mp = prio_data_in;
    evt_in <= 22'($random(seed) & $random(seed) & $random(seed));
    flag_clr_in <= 22'($random(seed) & $random(seed));
    {en_wr_in, prio_wr_in} <= 2'($random(seed));
    {en_data_in, prio_data_in} <= 42'({$random(seed), $random(seed)});
    {cpu_level_mask_bit1_in, cpu_level_mask_bit0_in} <= 2'($random(seed));
    halt_instruction_in <= ($random(seed) & 31) == 0;
    sleep_instruction_in <= ($random(seed) & 31) == 0;
    #1;
    chk("flags enable", {flags_out, enable_out}, {mf, me});
    chk("prio", prio_out, mp);
    chk("sysreq", sys_req_out, reqs(mf & me));
    chk("take", irq_take_out, et);
    if (et) chk("winner", {irq_sys_out, irq_lvl_out}, {w[3:0], wl[1:0]});
    chk("standby", {cpu_stop_out, low_speed_oscillator_stop_out,
      high_speed_oscillator_stop_out, wake_out},
      {mode != 0, mode == 2, mode == 2, ew});
  endtask : step

  initial begin
    repeat (20) @(posedge mclk_in);
    rst_b_in <= 1'h1;
    repeat (3000) step();
    @(posedge mclk_in);
    {evt_in, en_wr_in, prio_wr_in} <= '0;
    {halt_instruction_in, sleep_instruction_in} <= 2'h0;
    flag_clr_in <= '1;
    {wdt_nmi_en_in, wdt_nmi_evt_in} <= 2'h3;
    @(posedge mclk_in);
    {io_wr_in, wdt_nmi_evt_in} <= 2'h2;
    io_addr_in <= 24'h00_ff00;
    @(posedge mclk_in);
    io_addr_in <= 24'h00_ff01;
    @(posedge mclk_in);
    {io_wr_in, wdt_nmi_en_in, wdt_nmi_evt_in} <= 3'h1;
    @(posedge mclk_in);
    wdt_nmi_evt_in <= 1'h0;
    repeat (9) @(posedge mclk_in);
    #1 chk("nmi off", {nmi_unblocked_out, nmi_cnt}, {1'b1, 32'h0000_0000});
    @(posedge mclk_in);
    {en_wr_in, prio_wr_in, wdt_nmi_en_in} <= 3'h7;
    {en_data_in, prio_data_in, flag_clr_in} <= {42'h3ff_ffff_ffff, 22'h0};
    {cpu_level_mask_bit1_in, cpu_level_mask_bit0_in} <= 2'h0;
    @(posedge mclk_in);
    {en_wr_in, prio_wr_in, wdt_nmi_evt_in} <= 3'h1;
    evt_in <= 22'h00_0001;
    @(posedge mclk_in);
    {evt_in, wdt_nmi_evt_in} <= '0;
    repeat (9) @(posedge mclk_in);
    #1 chk("nmi", nmi_cnt, 1);
    summarize();
  end
endmodule : testbench

bind isc_top isc_sva #(.NTYPES(NTYPES), .NSYS(NSYS)) sva (.*);
